// *** pkg/pie_map.svh ***
// What this block does
// [RULE_01] Reset: priority 1, vector 0000h, non-maskable
// [RULE_02] NMI: priority 3, vector 0024h, software only
// [RULE_03] Converter done: level one, bit 0.1, 0004h
// [RULE_04] Pin requests: level one, 0.2/0001h, 0.3/0011h
// [RULE_05] Serial peripheral: level one, 0.4, 0005h
// [RULE_06] Serial receive: level one, 0.5, 0006h
// [RULE_07] Serial transmit: level one, 0.6, 0007h
// [RULE_08] CAN mailbox: level one, 0.7, 0040
// [RULE_09] CAN error: level one, 0.8, 0041
// [RULE_10] Timer one period: level two, 0.12, 0027h
// [RULE_11] Timer one compare: level two, 0.13, 0028h
// [RULE_12] Timer one underflow: level two, 0.14, 0029h
// [RULE_13] Timer one overflow: level two, 0.15, 002Ah
// [RULE_14] Timer three period: level two, 2.4, 002Fh
// [RULE_15] Timer three compare: level two, 2.5, 0030h
// [RULE_16] Timer three underflow: level two, 2.6, 0031h
// [RULE_17] Timer three overflow: level two, 2.7, 0032h
// [RULE_18] Absent peripherals' requests never assert
// [RULE_19] Compares to level two, 0.9-0.11, 2.1-2.3
// [RULE_20] Power faults to level one, 0.0 and 2.0
// [RULE_21] Lowest priority number pending is served first
// [RULE_22] Pin requests masked at source and level
// [RULE_23] Every source has its own vector code
`ifndef PIE_MAP_SVH
`define PIE_MAP_SVH
`define VEC_RESET 16'h0000
`define VEC_NMI 16'h0024
`define VEC_LEVEL_ONE 16'h0002
`define VEC_LEVEL_TWO 16'h0004
`define PRIO_RESET 6'h01
`define PRIO_NMI 6'h03
`define NUM_SRC 23
// Source index = overall priority minus four
`define CODE_TABLE {16'h0020, 16'h0019, 16'h0004, 16'h0001, 16'h0011, 16'h0005, \
    16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027, \
    16'h0028, 16'h0029, 16'h002A, 16'h0024, 16'h0025, 16'h0026, 16'h002F, 16'h0030, \
    16'h0031, 16'h0032}
// Pending bit position: {register, bit}
`define BIT_TABLE {6'h00, 6'h20, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, \
    6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h21, 6'h22, 6'h23, \
    6'h24, 6'h25, 6'h26, 6'h27}
// Sources 0..9 sit on level one, 10..23 on level two
`define LEVEL_ONE_LAST 9
// Source indices of the two pin requests, which carry their own enables
`define IDX_EXT_ONE 3
`define IDX_EXT_TWO 4
`endif

// *** pkg/pie_pkg.sv ***
`default_nettype none
package pie_pkg;
    typedef struct packed {
        logic fault_a;
        logic fault_b;
        logic converter_done;
        logic ext_one;
        logic ext_two;
        logic serial_periph;
        logic serial_receive;
        logic serial_transmit;
        logic can_mailbox;
        logic can_error;
        logic [2:0] compare_first;
        logic timer_one_period;
        logic timer_one_compare;
        logic timer_one_underflow;
        logic timer_one_overflow;
        logic [2:0] compare_second;
        logic timer_three_period;
        logic timer_three_compare;
        logic timer_three_underflow;
        logic timer_three_overflow;
    } src_req_t;

    typedef struct packed {
        logic [15:0] pend0;
        logic [15:0] pend2;
    } pend_regs_t;
endpackage
`default_nettype wire

// *** rtl/peripheral_interrupt_expander.sv ***
`include "pie_map.svh"
`default_nettype none
module peripheral_interrupt_expander
    import pie_pkg::*;
#(
    parameter logic [23:0] PRESENT = 24'hFF_FFFF
)(
    input wire logic clk,
    input wire logic nrst,
    input wire src_req_t req,
    input wire logic ext_one_enable,
    input wire logic ext_two_enable,
    input wire logic [1:0] core_level_mask,
    input wire logic watchdog_timeout,
    input wire logic nmi_soft,
    input wire logic ack_level_one,
    input wire logic ack_level_two,
    output logic core_level_one,
    output logic core_level_two,
    output logic reset_request,
    output logic nmi_request,
    output logic [15:0] peripheral_vector_code,
    output logic [15:0] core_vector_addr,
    output pend_regs_t peripheral_pending_reg,
    output pend_regs_t peripheral_ack_reg
);
    // ==========================================================
    // Source table
    localparam logic [23:0][15:0] CODES = `CODE_TABLE;
    localparam logic [23:0][5:0] BITS = `BIT_TABLE;

    function automatic logic [23:0] flatten(input src_req_t r);
        flatten = {r.fault_a, r.fault_b, r.converter_done, r.ext_one, r.ext_two,
            r.serial_periph, r.serial_receive, r.serial_transmit, r.can_mailbox,
            r.can_error, r.compare_first, r.timer_one_period, r.timer_one_compare,
            r.timer_one_underflow, r.timer_one_overflow, r.compare_second,
            r.timer_three_period, r.timer_three_compare, r.timer_three_underflow,
            r.timer_three_overflow};
    endfunction

    // Index 0 (msb of flatten) is overall priority 4
    function automatic logic [23:0] reorder(input logic [23:0] v);
        reorder = '0;
        for (int i = 0; i < 24; i++)
        begin
            reorder[i] = v[23 - i];
        end
    endfunction

    function automatic pend_regs_t to_regs(input logic [23:0] p);
        to_regs = '0;
        for (int i = 0; i < 24; i++)
        begin
            if (BITS[23 - i][5])
            begin
                to_regs.pend2[BITS[23 - i][3:0]] = p[i];
            end
            else
            begin
                to_regs.pend0[BITS[23 - i][3:0]] = p[i];
            end
        end
    endfunction

    // Lowest set index inside [lo, hi], or -1 when nothing there is pending
    function automatic int lowest_pending(input logic [23:0] p, input int lo, input int hi);
        lowest_pending = -1;
        // Scan downward so the lowest index, lowest priority number, wins
        for (int i = hi; i >= lo; i--)
        begin
            if (p[i])
            begin
                lowest_pending = i;
            end
        end
    endfunction

    // ==========================================================
    // Request qualification
    logic [23:0] raw;
    logic [23:0] raw_sync1_q;
    logic [23:0] raw_sync2_q;
    logic [23:0] pend_q;
    logic [23:0] pend_d;
    logic [23:0] ack_d;
    logic wd_sync1_q;
    logic wd_sync2_q;
    logic lvl1_d;
    logic lvl2_d;
    logic [15:0] code_d;
    logic [15:0] code_q;
    logic [15:0] addr_d;
    logic [15:0] addr_q;
    logic lvl1_q;
    logic lvl2_q;
    logic rst_q;
    logic nmi_q;
    logic [23:0] sync_d;
    logic wd_d;
    logic [1:0] mask_d;
    logic rst_d;
    logic nmi_d;
    pend_regs_t pend_reg_d;
    pend_regs_t ack_reg_d;

    // Pins pass both flops untouched; gating happens after, so a glitch on
    // an enable can never fold into the synchroniser input
    always_comb
    begin
        sync_d = reorder(flatten(req));
        wd_d = watchdog_timeout;
        mask_d = core_level_mask;
    end
    logic [1:0] mask_sync1_q;
    logic [1:0] mask_sync2_q;

    always_comb
    begin
        raw = raw_sync2_q & reorder(PRESENT); // RULE_18
        raw[`IDX_EXT_ONE] = raw[`IDX_EXT_ONE] & ext_one_enable; // RULE_22
        raw[`IDX_EXT_TWO] = raw[`IDX_EXT_TWO] & ext_two_enable; // RULE_22
    end

    // ==========================================================
    // Pending, ack and vector selection
    always_comb
    begin
        int sel1;
        int sel2;
        sel1 = lowest_pending(pend_q, 0, `LEVEL_ONE_LAST); // RULE_21
        sel2 = lowest_pending(pend_q, `LEVEL_ONE_LAST + 1, `NUM_SRC); // RULE_21
        pend_d = pend_q | raw; // RULE_03
        ack_d = '0;
        lvl1_d = (sel1 >= 0) && !mask_sync2_q[0]; // RULE_22 RULE_20 RULE_04
        lvl2_d = (sel2 >= 0) && !mask_sync2_q[1]; // RULE_19 RULE_10
        code_d = code_q;
        addr_d = addr_q;
        // Level one outranks level two at the core
        if (ack_level_one && sel1 >= 0)
        begin
            code_d = CODES[23 - sel1]; // RULE_23 RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
            addr_d = `VEC_LEVEL_ONE;
            // A request still high at ack sets pending again: set wins
            pend_d[sel1] = raw[sel1];
            ack_d[sel1] = 1'b1;
        end
        else if (ack_level_two && sel2 >= 0)
        begin
            code_d = CODES[23 - sel2]; // RULE_11 RULE_12 RULE_13 RULE_14 RULE_15 RULE_16 RULE_17
            addr_d = `VEC_LEVEL_TWO;
            pend_d[sel2] = raw[sel2];
            ack_d[sel2] = 1'b1;
        end
        if (wd_sync2_q)
        begin
            addr_d = `VEC_RESET; // RULE_01
        end
        else if (nmi_soft)
        begin
            addr_d = `VEC_NMI; // RULE_02
        end
        rst_d = wd_sync2_q; // RULE_01
        nmi_d = nmi_soft; // RULE_02
        pend_reg_d = to_regs(pend_d);
        ack_reg_d = to_regs(ack_d);
    end

    // ==========================================================
    // Synchroniser flops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            raw_sync1_q <= '0;
            raw_sync2_q <= '0;
            wd_sync1_q <= 1'b0;
            wd_sync2_q <= 1'b0;
            // Both levels start masked so no level request reaches the core before setup
            mask_sync1_q <= 2'h3;
            mask_sync2_q <= 2'h3;
        end
        else
        begin
            raw_sync1_q <= sync_d;
            raw_sync2_q <= raw_sync1_q;
            wd_sync1_q <= wd_d;
            wd_sync2_q <= wd_sync1_q;
            mask_sync1_q <= mask_d;
            mask_sync2_q <= mask_sync1_q;
        end
    end

    // ==========================================================
    // Pending state
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_q <= '0;
        end
        else
        begin
            pend_q <= pend_d;
        end
    end

    // ==========================================================
    // Core-facing registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl1_q <= 1'b0;
            lvl2_q <= 1'b0;
            code_q <= 16'h0000;
            addr_q <= `VEC_RESET; // RULE_01
            rst_q <= 1'b1;
            nmi_q <= 1'b0;
            peripheral_pending_reg <= '0;
            peripheral_ack_reg <= '0;
        end
        else
        begin
            lvl1_q <= lvl1_d;
            lvl2_q <= lvl2_d;
            code_q <= code_d;
            addr_q <= addr_d;
            rst_q <= rst_d; // RULE_01
            nmi_q <= nmi_d; // RULE_02
            peripheral_pending_reg <= pend_reg_d;
            peripheral_ack_reg <= ack_reg_d;
        end
    end

    always_comb
    begin
        core_level_one = lvl1_q;
        core_level_two = lvl2_q;
        reset_request = rst_q;
        nmi_request = nmi_q;
        peripheral_vector_code = code_q;
        core_vector_addr = addr_q;
    end
endmodule
`default_nettype wire

// *** verification/pie_chk.sv ***
`default_nettype none
module pie_chk
    import pie_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic nmi_soft,
    input wire logic watchdog_timeout,
    input wire logic [1:0] core_level_mask,
    input wire logic ack_level_one,
    input wire logic ack_level_two,
    input wire logic core_level_one,
    input wire logic core_level_two,
    input wire logic reset_request,
    input wire logic nmi_request,
    input wire logic [15:0] peripheral_vector_code,
    input wire logic [15:0] core_vector_addr,
    input wire pend_regs_t peripheral_pending_reg,
    input wire pend_regs_t peripheral_ack_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    nmi_copy_a: assert property (nmi_soft |=> nmi_request)
        else $error("nmi request missing");
    wd_raise_a: assert property (watchdog_timeout [*4] |-> reset_request)
        else $error("watchdog reset missing");
    wd_quiet_a: assert property (!watchdog_timeout [*4] |-> !reset_request)
        else $error("spurious reset request");
    mask_one_a: assert property (core_level_mask[0] [*5] |-> !core_level_one)
        else $error("masked level one asserted");
    mask_two_a: assert property (core_level_mask[1] [*5] |-> !core_level_two)
        else $error("masked level two asserted");
    addr_one_a: assert property (ack_level_one && core_level_one && !nmi_soft && !reset_request
        |=> core_vector_addr == 16'h0002) else $error("level one address wrong");
    addr_two_a: assert property (ack_level_two && !ack_level_one && core_level_two && !nmi_soft
        && !reset_request |=> core_vector_addr == 16'h0004) else $error("level two addr");
    code_one_a: assert property (ack_level_one && core_level_one |=> peripheral_vector_code
        inside {16'h0001, 16'h0011, 16'h0019, 16'h0020, [16'h0004:16'h0007], 16'h0040, 16'h0041})
        else $error("level one code wrong");
    code_two_a: assert property (ack_level_two && !ack_level_one && core_level_two |=>
        peripheral_vector_code inside {[16'h0021:16'h002A], [16'h002F:16'h0032]})
        else $error("level two code wrong");
    pend_lvl_a: assert property ($rose(core_level_one) |-> |peripheral_pending_reg.pend0[8:0]
        || peripheral_pending_reg.pend2[0]) else $error("level without pending");
    ack_pulse_a: assert property (ack_level_one && core_level_one
        |=> peripheral_ack_reg != '0) else $error("ack register pulse missing");
    ack_idle_a: assert property (!ack_level_one && !ack_level_two
        |=> peripheral_ack_reg == '0) else $error("ack register not idle");
    cover property (ack_level_one && core_level_one);
    cover property (ack_level_two && !ack_level_one && core_level_two);
    cover property (nmi_request);
endmodule
`default_nettype wire

// *** verification/core_model.sv ***
`default_nettype none
module core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic lvl_one,
    input wire logic lvl_two,
    input wire logic [3:0] dly,
    output logic ack_one,
    output logic ack_two
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // ==========
    // Acknowledge after a chosen wait; hold off while the level settles
    always @(posedge clk or negedge nrst)
    begin
        ack_one <= 1'b0;
        ack_two <= 1'b0;
        if (!nrst)
            cnt <= 0;
        else if (cnt < 0)
            cnt <= cnt + 1;
        else if (lvl_one || lvl_two)
        begin
            cnt <= (cnt >= int'(dly)) ? -4 : cnt + 1;
            ack_one <= (cnt >= int'(dly)) && lvl_one;
            ack_two <= (cnt >= int'(dly)) && !lvl_one;
        end
        else
            cnt <= 0;
    end
endmodule
`default_nettype wire

// *** verification/peripheral_interrupt_expander_map_tb.sv ***
`default_nettype none
module peripheral_interrupt_expander_map_tb;
    import pie_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] PRES = 24'hFF_3FFF;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    src_req_t req = '0;
    logic en1 = 1'b0;
    logic en2 = 1'b0;
    logic [1:0] mask = 2'b11;
    logic wd = 1'b0;
    logic nmi = 1'b0;
    logic [3:0] dly = 4'h0;
    logic ack1, ack2, lvl1, lvl2, rst_rq, nmi_rq;
    logic [15:0] code, addr, a;
    pend_regs_t pend, exp, ackr;
    logic [23:0] v;
    logic [31:0] r = 32'h0000_885b;
    logic [15:0] q[$];
    int n_fail = 0;
    int checks_done = 0;
    int i;
    logic [15:0] codes [0:23] = '{16'h0020, 16'h0019, 16'h0004, 16'h0001, 16'h0011, 16'h0005,
        16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027,
        16'h0028, 16'h0029, 16'h002A, 16'h0024, 16'h0025, 16'h0026, 16'h002F, 16'h0030,
        16'h0031, 16'h0032};
    always #2 clk = ~clk;
    peripheral_interrupt_expander #(.PRESENT(PRES)) u_dut (.clk(clk), .nrst(nrst), .req(req),
        .ext_one_enable(en1), .ext_two_enable(en2), .core_level_mask(mask),
        .watchdog_timeout(wd), .nmi_soft(nmi), .ack_level_one(ack1), .ack_level_two(ack2),
        .core_level_one(lvl1), .core_level_two(lvl2), .reset_request(rst_rq),
        .nmi_request(nmi_rq), .peripheral_vector_code(code), .core_vector_addr(addr),
        .peripheral_pending_reg(pend), .peripheral_ack_reg(ackr));
    core_model u_core (.clk(clk), .nrst(nrst), .lvl_one(lvl1), .lvl_two(lvl2), .dly(dly),
        .ack_one(ack1), .ack_two(ack2));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ==========
    // Sequence
    initial
    begin
        repeat (10) @(negedge clk);
        chk({15'h0, rst_rq, addr}, 32'h0001_0000);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        wd = 1'b1;
        repeat (5) @(negedge clk);
        chk(32'(rst_rq), 32'h0000_0001);
        wd = 1'b0;
        repeat (6) @(negedge clk);
        nmi = 1'b1;
        @(negedge clk);
        nmi = 1'b0;
        chk({15'h0, nmi_rq, addr}, 32'h0001_0024);
        $display("test reset and nmi done");
        for (int t = 0; t < 12; t++)
        begin
            r = xs(r);
            v = r[23:0];
            r = xs(r);
            {en2, en1, dly} = r[5:0];
            mask = 2'b11;
            exp = '0;
            for (int b = 23; b >= 0; b--)
                if (v[b] && PRES[b] && !(b == 20 && !en1) && !(b == 19 && !en2))
                begin
                    i = 23 - b;
                    q.push_back(codes[i]);
                    exp[i == 0 ? 16 : i == 1 ? 0 : i <= 16 ? i + 15 : i - 16] = 1'b1;
                end
            req = v;
            @(negedge clk);
            req = '0;
            repeat (6) @(negedge clk);
            chk(pend, exp);
            mask = 2'b00;
            for (int k = 0; k < 600 && q.size() > 0; k++)
            begin
                @(negedge clk);
                if (ack1 || ack2)
                begin
                    a = ack1 ? 16'h0002 : 16'h0004;
                    @(negedge clk);
                    chk({code, addr}, {q.pop_front(), a});
                end
            end
            if (q.size() > 0)
            begin
                n_fail++;
                results();
            end
            repeat (8) @(negedge clk);
            chk(pend, 32'h0000_0000);
            $display("test %0d done", t);
        end
        results();
    end
endmodule
bind peripheral_interrupt_expander pie_chk u_chk (.clk, .nrst, .nmi_soft, .watchdog_timeout,
    .core_level_mask, .ack_level_one, .ack_level_two, .core_level_one, .core_level_two,
    .reset_request, .nmi_request, .peripheral_vector_code, .core_vector_addr,
    .peripheral_pending_reg, .peripheral_ack_reg);
`default_nettype wire
